// *** epfr_recorder.sv ***
// Contract
// - Each engine captures its first page fault.
// - Later faults ignored while valid is set; a fault in the same cycle as a software clear is captured.
// - Valid bit zero set on capture.
// - Bits 31:12 hold faulting page address.
// - Bit 11 holds table select.
// - Bits 10:3 hold requester source id.
// - Bits 2:1 hold fault kind.
// - Fields frozen until software clears valid.
// - Only software clears; clear zeroes all fields; a fault in the clear's cycle is stored instead.
//
// Top of the engine page fault recorder: one record for one engine.
// Assumes fault reports are one-cycle pulses synchronous to clk_in and that
// register accesses are single-cycle strobes with a byte offset.
// The record itself lives in the storage module; this level decodes the offset,
// qualifies captures and clears, and registers every output.
`default_nettype none

module epfr_recorder (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Fault report from the translation logic.
    input  wire logic        fault_valid_in,
    input  wire logic [19:0] fault_page_addr_in,
    input  wire logic        fault_table_sel_in,
    input  wire logic [7:0]  fault_source_id_in,
    input  wire logic [1:0]  fault_kind_in,
    // Register access.
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    // Current record for the engine.
    output logic [31:0]      record_out,
    output logic             record_valid_out
);
    epfr_fault_if fault_bus ();

    logic [31:0] record;
    logic        hit;
    logic        held;
    logic [31:0] rdata_nxt;
    logic [31:0] reg_rdata_r;
    logic        reg_rvalid_r;
    logic [31:0] record_r;
    logic        record_valid_r;

    // Decode and capture qualification. A fault is taken while nothing is held,
    // or while software clears the record: a clear opens the record in the same
    // cycle, so a fault racing it is kept rather than lost behind the old flag.
    assign hit                 = reg_addr_in == epfr_pkg::EPFR_GRAPHICS_ENGINE_FAULT_RECORD_OFS;
    assign held                = record[epfr_pkg::EPFR_VALID_BIT];
    assign fault_bus.capture   = fault_valid_in && (!held || fault_bus.clear);
    assign fault_bus.page_addr = fault_page_addr_in;
    assign fault_bus.table_sel = fault_table_sel_in;
    assign fault_bus.source_id = fault_source_id_in;
    assign fault_bus.kind      = fault_kind_in;
    // Software writing zero to valid clears; writing one changes nothing,
    // since the fields are hardware-owned and a write must not forge a fault.
    assign fault_bus.clear     = reg_write_in && hit
                               && !reg_wdata_in[epfr_pkg::EPFR_VALID_BIT];
    assign rdata_nxt           = hit ? record : 32'h0000_0000;

    // Record storage; its output is the live record that decode and reads use.
    epfr_record u_record (
        .clk_in     (clk_in),
        .reset_in   (reset_in),
        .fault      (fault_bus),
        .record_out (record)
    );

    // Registered read port and mirrored record outputs.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reg_rdata_r    <= 32'h0000_0000;
            reg_rvalid_r   <= 1'b0;
            record_r       <= epfr_pkg::EPFR_RECORD_RESET;
            record_valid_r <= 1'b0;
        end else begin
            reg_rdata_r    <= reg_read_in ? rdata_nxt : 32'h0000_0000;
            reg_rvalid_r   <= reg_read_in;
            record_r       <= record;
            record_valid_r <= held;
        end
    end

    assign reg_rdata_out    = reg_rdata_r;
    assign reg_rvalid_out   = reg_rvalid_r;
    assign record_out       = record_r;
    assign record_valid_out = record_valid_r;

    // Capture path: valid rises one edge after a fault meets an empty record.
    chk_valid_sets: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_valid_in && !held) |=> record[0])
        else $error("Valid not set on first fault.");

    // A held record moves only when software clears it.
    chk_fields_frozen: assert property (@(posedge clk_in) disable iff (reset_in)
        (held && !fault_bus.clear) |=> $stable(record))
        else $error("Held record changed without clear.");

    // A clear with no fault beside it returns every field to zero.
    chk_clear_zeroes: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_bus.clear && !fault_bus.capture) |=> record == 32'h0000_0000)
        else $error("Clear left fields nonzero.");

    // Hardware alone never drops the valid flag.
    chk_hw_no_clear: assert property (@(posedge clk_in) disable iff (reset_in)
        (held && !fault_bus.clear) |=> held)
        else $error("Valid dropped without software.");

    // A clear with no fault beside it drops the valid flag.
    chk_clear_drops_valid: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_bus.clear && !fault_valid_in) |=> !record[epfr_pkg::EPFR_VALID_BIT])
        else $error("Clear left valid set.");

    // A fault racing the clear is kept, flag and address alike.
    chk_clear_race: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_bus.clear && fault_valid_in) |=> record[0]
            && record[31:12] == $past(fault_page_addr_in))
        else $error("Fault lost during clear.");

    // The raced fault's kind and source are its own, not the old record's.
    chk_race_fields: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_bus.clear && fault_valid_in) |=> record[2:1] == $past(fault_kind_in)
            && record[10:3] == $past(fault_source_id_in))
        else $error("Raced fault fields not kept.");

    // The first fault's page address lands in the top field.
    chk_first_addr: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_valid_in && !held) |=> record[31:12] == $past(fault_page_addr_in))
        else $error("Wrong address captured.");

    // The first fault's kind lands in its field.
    chk_kind_field: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_valid_in && !held) |=> record[2:1] == $past(fault_kind_in))
        else $error("Wrong fault kind captured.");

    // Source id and table select land together.
    chk_source_field: assert property (@(posedge clk_in) disable iff (reset_in)
        (fault_valid_in && !held) |=> record[10:3] == $past(fault_source_id_in)
            && record[11] == $past(fault_table_sel_in))
        else $error("Wrong source or table captured.");

    // Table select on its own, for every capture including a raced one.
    chk_table_field: assert property (@(posedge clk_in) disable iff (reset_in)
        fault_bus.capture |=> record[epfr_pkg::EPFR_TSEL_BIT] == $past(fault_table_sel_in))
        else $error("Wrong table select captured.");

    // A later fault while the record is held leaves every bit alone.
    chk_later_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
        (held && fault_valid_in && !fault_bus.clear) |=> record == $past(record))
        else $error("Later fault disturbed the record.");

    // Valid never rises without a fault, so no write can forge a record.
    chk_no_forged_valid: assert property (@(posedge clk_in) disable iff (reset_in)
        (!held && !fault_valid_in) |=> !record[epfr_pkg::EPFR_VALID_BIT])
        else $error("Valid rose without a fault.");

    // An empty record reads as all zero, whatever emptied it.
    chk_idle_all_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        !record[epfr_pkg::EPFR_VALID_BIT] |-> record == 32'h0000_0000)
        else $error("Empty record holds stale fields.");

    // Writing one to valid changes nothing; the fields are not software-writable.
    chk_set_write_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        (reg_write_in && hit && reg_wdata_in[0] && !fault_valid_in) |=> $stable(record))
        else $error("Write of one altered the record.");

    // A write to another offset never reaches the record.
    chk_foreign_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (reg_write_in && !hit && !fault_valid_in) |=> $stable(record))
        else $error("Foreign write altered the record.");

    // The read answer follows the strobe by one edge and carries that edge's record.
    chk_read_data: assert property (@(posedge clk_in) disable iff (reset_in)
        (reg_read_in && hit) |=> reg_rvalid_out && reg_rdata_out == $past(record))
        else $error("Read answer wrong or late.");

    // Reads of other offsets answer with zero, so nothing else leaks out.
    chk_unmapped_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (reg_read_in && !hit) |=> reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
        else $error("Unmapped read not zero.");

    // With no read the answer lines rest at zero.
    chk_idle_read: assert property (@(posedge clk_in) disable iff (reset_in)
        !reg_read_in |=> !reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
        else $error("Read answer without a read.");

    // The exported copies trail the record by one edge; the guard skips the
    // edge after a reset, where the copy and the record were reset apart.
    chk_record_mirror: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) |-> record_out == $past(record))
        else $error("Exported record does not follow.");

    // The exported valid trails the held flag by one edge, with the same guard.
    chk_valid_mirror: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) |-> record_valid_out == $past(held))
        else $error("Exported valid does not follow.");

    // An exported record with valid low is all zero.
    chk_out_zero_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        !record_valid_out |-> record_out == 32'h0000_0000)
        else $error("Exported empty record not zero.");

    // Reset empties the record and quiets every output.
    chk_reset_outputs: assert property (@(posedge clk_in)
        reset_in |=> record_out == 32'h0000_0000 && !record_valid_out
            && !reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
        else $error("Outputs not zero after reset.");

    // The internal record is empty one edge after any reset edge.
    chk_reset_zero: assert property (@(posedge clk_in)
        reset_in |=> record == 32'h0000_0000)
        else $error("Record not zero after reset.");

endmodule : epfr_recorder

`default_nettype wire

// *** epfr_pkg.sv ***
// Package for the engine page fault recorder.
// Assumes a 32-bit register path with word addresses given as byte offsets.
`default_nettype none

package epfr_pkg;

    // Register offset and reset value.
    localparam logic [15:0] EPFR_GRAPHICS_ENGINE_FAULT_RECORD_OFS = 16'h4094;
    localparam logic [31:0] EPFR_RECORD_RESET                     = 32'h0000_0000;

    // Field positions within the record.
    localparam int EPFR_ADDR_LSB   = 12;
    localparam int EPFR_ADDR_MSB   = 31;
    localparam int EPFR_TSEL_BIT   = 11;
    localparam int EPFR_REQUESTER_SOURCE_ID_LSB  = 3;
    localparam int EPFR_REQUESTER_SOURCE_ID_MSB  = 10;
    localparam int EPFR_TYPE_LSB   = 1;
    localparam int EPFR_TYPE_MSB   = 2;
    localparam int EPFR_VALID_BIT  = 0;

    // Fault kind encodings.
    typedef enum logic [1:0] {
        EPFR_FAULT_PAGE              = 2'h0,
        EPFR_FAULT_INVALID_DIR       = 2'h1,
        EPFR_FAULT_UNLOADED_DIR      = 2'h2,
        EPFR_FAULT_INVALID_UNLOADED  = 2'h3
    } epfr_fault_kind_t;

endpackage : epfr_pkg

`default_nettype wire

// *** epfr_fault_if.sv ***
// Interface carrying one fault report from the decode logic to the record.
// Assumes the reporter and record share clk_in.
`default_nettype none

interface epfr_fault_if;
    logic        capture;
    logic [19:0] page_addr;
    logic        table_sel;
    logic [7:0]  source_id;
    logic [1:0]  kind;
    logic        clear;

    modport source (output capture, page_addr, table_sel, source_id, kind, clear);
    modport sink   (input  capture, page_addr, table_sel, source_id, kind, clear);
endinterface : epfr_fault_if

`default_nettype wire

// *** epfr_record.sv ***
// Record storage: holds the first captured fault until software clears it.
// Assumes capture and clear are already qualified by the top module.
`default_nettype none

module epfr_record (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Qualified capture and clear.
    epfr_fault_if.sink       fault,
    // Stored record.
    output logic [31:0]      record_out
);
    logic [31:0] record_r;
    logic [31:0] record_nxt;
    logic [31:0] captured;

    // Captured word assembled from the report fields.
    assign captured = {fault.page_addr, fault.table_sel, fault.source_id, fault.kind, 1'b1};

    // Capture wins over a clear in the same cycle so the new fault is kept.
    assign record_nxt = fault.capture ? captured
                      : fault.clear   ? epfr_pkg::EPFR_RECORD_RESET
                      : record_r;

    // Record flop, zero out of reset.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            record_r <= epfr_pkg::EPFR_RECORD_RESET;
        end else begin
            record_r <= record_nxt;
        end
    end

    assign record_out = record_r;

    // A capture lands whole in the next cycle.
    chk_capture_lands: assert property (@(posedge clk_in) disable iff (reset_in)
        fault.capture |=> record_r == $past(captured))
        else $error("Captured fault not stored.");

endmodule : epfr_record

`default_nettype wire

// *** epfr_xlate_model.sv ***
// Behavioural translation logic that reports page faults one at a time.
// Assumes it shares clk_in with the recorder and is driven by bench calls.
`default_nettype none

module epfr_xlate_model (
    // Clock.
    input  wire logic       clk_in,
    // Fault report.
    output var logic        fault_valid_out,
    output var logic [19:0] page_addr_out,
    output var logic        table_sel_out,
    output var logic [7:0]  source_id_out,
    output var logic [1:0]  kind_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // The strobe is quiet until the first report is sent.
    initial begin
        fault_valid_out = 1'b0;
        {page_addr_out, table_sel_out, source_id_out, kind_out} = 31'h0;
    end

    // One-cycle report; fields are inverted afterwards so stale data never looks valid.
    task report(input logic [19:0] a, input logic t, input logic [7:0] s, input logic [1:0] k);
        @(posedge clk_in);
        fault_valid_out <= 1'b1;
        {page_addr_out, table_sel_out, source_id_out, kind_out} <= {a, t, s, k};
        @(posedge clk_in);
        fault_valid_out <= 1'b0;
        {page_addr_out, table_sel_out, source_id_out, kind_out} <= ~{a, t, s, k};
    endtask : report
endmodule : epfr_xlate_model

`default_nettype wire

// *** engine_page_fault_recorder_tb.sv ***
// Self-checking bench for the engine page fault recorder.
// Assumes the translation model above and the recorder top module.
`default_nettype none

module engine_page_fault_recorder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] OFS = epfr_pkg::EPFR_GRAPHICS_ENGINE_FAULT_RECORD_OFS;
    logic clk_in = 1'b0, reset_in = 1'b1, fv, ts, rw = 1'b0, rr = 1'b0, rv, recv;
    logic [19:0] pa;
    logic [7:0]  sid;
    logic [1:0]  kd;
    logic [15:0] ra = 16'h0;
    logic [31:0] wd = 32'h0, rd_d, rec_o, d;
    int mismatches = 0, checks = 0;

    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;

    epfr_xlate_model u_xlate (.clk_in(clk_in), .fault_valid_out(fv), .page_addr_out(pa),
        .table_sel_out(ts), .source_id_out(sid), .kind_out(kd));
    epfr_recorder i_dut (.clk_in(clk_in), .reset_in(reset_in), .fault_valid_in(fv),
        .fault_page_addr_in(pa), .fault_table_sel_in(ts), .fault_source_id_in(sid),
        .fault_kind_in(kd), .reg_write_in(rw), .reg_read_in(rr), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_rdata_out(rd_d), .reg_rvalid_out(rv),
        .record_out(rec_o), .record_valid_out(recv));

    task finish_test();
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] rec(logic [19:0] a, logic t, logic [7:0] s, logic [1:0] k);
        return {a, t, s, k, 1'b1};
    endfunction : rec

    // Read strobe held one cycle; the answer is awaited under a bound.
    task rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk_in);
        rr <= 1'b1;
        ra <= a;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            rr <= 1'b0;
            #1;
            if (rv === 1'b1) begin
                v = rd_d;
                return;
            end
        end
        mismatches++;
        finish_test();
    endtask : rd

    task wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk_in);
        {rw, ra, wd} <= {1'b1, a, v};
        @(posedge clk_in);
        rw <= 1'b0;
    endtask : wr

    task test_reset();
        rd(OFS, d);
        chk("reset_read", d, epfr_pkg::EPFR_RECORD_RESET);
        chk("reset_record", rec_o, 32'h0);
    endtask : test_reset

    // Every fault kind and both tables, each cleared afterwards.
    task test_kinds();
        for (int k = 0; k < 4; k++) begin
            u_xlate.report(20'hf0a51 ^ 20'(k), k[0], 8'h3c ^ 8'(k), 2'(k));
            rd(OFS, d);
            chk("capture", d, rec(20'hf0a51 ^ 20'(k), k[0], 8'h3c ^ 8'(k), 2'(k)));
            chk("valid_out", {31'h0, recv}, 32'h1);
            wr(OFS, 32'h0);
            rd(OFS, d);
            chk("cleared", d, 32'h0);
        end
    endtask : test_kinds

    // Later faults, set writes and foreign writes leave the record frozen.
    task test_freeze();
        u_xlate.report(20'h12345, 1'b1, 8'ha7, 2'h2);
        u_xlate.report(20'h6789a, 1'b0, 8'h5e, 2'h1);
        wr(OFS, 32'hffff_ffff);
        wr(16'h4194, 32'h0);
        rd(OFS, d);
        chk("frozen", d, rec(20'h12345, 1'b1, 8'ha7, 2'h2));
        chk("frozen_out", rec_o, rec(20'h12345, 1'b1, 8'ha7, 2'h2));
        rd(16'h4098, d);
        chk("unmapped", d, 32'h0);
    endtask : test_freeze

    // A fault arriving with the clear is the one kept.
    task test_same_cycle();
        fork
            u_xlate.report(20'h0beef, 1'b0, 8'h81, 2'h3);
            wr(OFS, 32'h0);
        join
        rd(OFS, d);
        chk("same_cycle", d, rec(20'h0beef, 1'b0, 8'h81, 2'h3));
    endtask : test_same_cycle

    // A reset in mid-run empties a held record, and the next fault is taken.
    task test_mid_reset();
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(OFS, d);
        chk("mid_reset_read", d, epfr_pkg::EPFR_RECORD_RESET);
        chk("mid_reset_record", rec_o, 32'h0);
        chk("mid_reset_valid", {31'h0, recv}, 32'h0);
        u_xlate.report(20'h00c3f, 1'b0, 8'h18, 2'h0);
        rd(OFS, d);
        chk("after_reset", d, rec(20'h00c3f, 1'b0, 8'h18, 2'h0));
    endtask : test_mid_reset

    // Main sequence.
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        test_reset();
        test_kinds();
        test_freeze();
        test_same_cycle();
        test_mid_reset();
        finish_test();
    end
endmodule : engine_page_fault_recorder_tb

`default_nettype wire
